// File: hw/rpm_core.sv
// power-state sequencer and receiver configuration with apb registers
`timescale 1ns/100ps
`default_nettype none
module rpm_core #(
    parameter int unsigned P_WAKE_HOLD_CYC = rpm_pkg::RPM_WAKE_HOLD_CYC
) (
    input  wire logic           i_clk,                  // 200 mhz clock
    input  wire logic           i_rst_n,                // async reset, low
    input  wire logic           i_psel,                 // apb select
    input  wire logic           i_penable,              // apb enable
    input  wire logic           i_pwrite,               // apb direction
    input  wire logic [11:0]    i_paddr,                // apb byte address
    input  wire logic [31:0]    i_pwdata,               // apb write data
    output logic      [31:0]    o_prdata,               // apb read data
    output logic                o_pready,               // apb ready
    output logic                o_pslverr,              // apb error
    input  wire logic           i_main_enable,          // main enable pin
    input  wire logic           i_secondary_wake_input, // wake pin
    input  wire logic           i_supply_settled,       // regulators settled
    input  wire logic           i_osc_stable,           // oscillator stable
    output rpm_pkg::rpm_pwr_t   o_pwr,                  // power controls
    output rpm_pkg::rpm_rx_t    o_rx,                   // receiver controls
    output logic                o_ready                 // ready to communicate
);
    import rpm_pkg::*;

    // index match for a byte address
    function automatic logic f_hit(input logic [11:0] a, input logic [7:0] idx);
        f_hit = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // tuning preset for a protocol selection
    function automatic logic [7:0] f_preset(input logic [7:0] p);
        logic [7:0] v;
        v = RPM_PRE_G3;
        case (p[3:2])
            2'h0:    v = RPM_PRE_G0;
            2'h1:    v = RPM_PRE_G1;
            2'h2:    v = RPM_PRE_G2;
            default: v = RPM_PRE_G3;
        endcase
        return v;
    endfunction

    // pin synchronisers: three stages, filtered level when stages two and three agree
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [3:0] f_q;
    logic       wake_prev_q;
    wire  [3:0] pins = {i_osc_stable, i_supply_settled, i_secondary_wake_input, i_main_enable};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q        <= 4'h0;
            s2_q        <= 4'h0;
            s3_q        <= 4'h0;
            f_q         <= 4'h0;
            wake_prev_q <= 1'b0;
        end else begin
            s1_q        <= pins;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            f_q         <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
            wake_prev_q <= f_q[1];
        end
    end

    // filtered pin levels and wake edge
    wire en_f      = f_q[0];
    wire wake_f    = f_q[1];
    wire settled_f = f_q[2];
    wire osc_f     = f_q[3];
    wire wake_rise = wake_f & ~wake_prev_q;

    // registers
    logic [7:0] chip_q;
    logic [7:0] proto_q;
    logic [7:0] rxtune_q;
    logic       pready_q;
    logic       pslverr_q;
    logic [31:0] prdata_q;

    // apb decode
    wire access    = i_psel & i_penable;
    wire commit    = access & pready_q;
    wire wr_commit = commit & i_pwrite & ~pslverr_q;
    wire hit_chip  = f_hit(i_paddr, RPM_IDX_CHIP);
    wire hit_proto = f_hit(i_paddr, RPM_IDX_PROTO);
    wire hit_tune  = f_hit(i_paddr, RPM_IDX_RXTUNE);
    wire hit_stat  = f_hit(i_paddr, RPM_IDX_STATUS);
    wire mapped    = hit_chip | hit_proto | hit_tune | (hit_stat & ~i_pwrite);

    // state machine
    rpm_state_t st_q;
    rpm_state_t st_d;
    logic       by_wake_q;
    logic       by_wake_d;
    logic [15:0] hold_cnt_q;
    wire hold_done = hold_cnt_q == 16'(P_WAKE_HOLD_CYC - 1);
    wire up_ok     = settled_f & osc_f;
    wire idle_st   = (st_q == RPM_ST_OFF) | (st_q == RPM_ST_SLEEP);

    // read mux
    wire [7:0] stat_v = {st_q, en_f, settled_f, osc_f};
    wire [7:0] rd_v   = hit_chip  ? chip_q   :
                        hit_proto ? proto_q  :
                        hit_tune  ? rxtune_q :
                        hit_stat  ? stat_v   : 8'h00;

    // apb slave: one wait state, data and error captured on the same edge that raises ready
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access & ~pready_q) begin
                prdata_q <= (mapped & ~i_pwrite) ? {24'h000000, rd_v} : 32'h0000_0000;
            end
        end
    end

    // register writes; protocol write reloads the tuning preset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chip_q   <= RPM_CHIP_RST;
            proto_q  <= RPM_PROTO_RST;
            rxtune_q <= RPM_RXTUNE_RST;
        end else if (wr_commit) begin
            if (hit_chip) begin
                chip_q <= i_pwdata[7:0];
            end
            if (hit_proto) begin
                proto_q  <= i_pwdata[7:0];
                rxtune_q <= f_preset(i_pwdata[7:0]);
            end
            if (hit_tune) begin
                rxtune_q <= i_pwdata[7:0];
            end
        end
    end

    // next state of the power sequencer
    always_comb begin
        st_d      = st_q;
        by_wake_d = by_wake_q;
        case (st_q)
            RPM_ST_OFF: begin
                if (en_f) begin
                    st_d      = RPM_ST_START;
                    by_wake_d = 1'b0;
                end else if (wake_rise) begin
                    st_d      = RPM_ST_START;
                    by_wake_d = 1'b1;
                end
            end
            RPM_ST_SLEEP: begin
                if (en_f) begin
                    st_d      = RPM_ST_START;
                    by_wake_d = 1'b0;
                end else if (!wake_f) begin
                    st_d = RPM_ST_OFF;
                end
            end
            RPM_ST_START: begin
                if (en_f) begin
                    by_wake_d = 1'b0;
                end
                if (!en_f && !by_wake_q) begin
                    st_d = wake_f ? RPM_ST_SLEEP : RPM_ST_OFF;
                end else if (up_ok) begin
                    st_d = en_f ? RPM_ST_ACT : RPM_ST_HOLD;
                end
            end
            RPM_ST_HOLD: begin
                if (en_f) begin
                    st_d      = RPM_ST_ACT;
                    by_wake_d = 1'b0;
                end else if (hold_done) begin
                    st_d = wake_f ? RPM_ST_SLEEP : RPM_ST_OFF;
                end
            end
            RPM_ST_ACT: begin
                if (!en_f) begin
                    st_d = wake_f ? RPM_ST_SLEEP : RPM_ST_OFF;
                end
            end
            default: begin
                st_d      = RPM_ST_OFF;
                by_wake_d = 1'b0;
            end
        endcase
    end

    // sequencer state and wake hold counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q       <= RPM_ST_OFF;
            by_wake_q  <= 1'b0;
            hold_cnt_q <= 16'h0000;
        end else begin
            st_q       <= st_d;
            by_wake_q  <= by_wake_d;
            hold_cnt_q <= (st_q == RPM_ST_HOLD) ? hold_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    // power controls from state and chip status
    wire act     = st_q == RPM_ST_ACT;
    wire stby    = chip_q[RPM_CS_STBY];
    wire tx_on   = act & ~stby & chip_q[RPM_CS_TX];
    wire rx_on   = act & ~stby & (chip_q[RPM_CS_TX] | chip_q[RPM_CS_RX]);
    rpm_pwr_t pwr_d;
    assign pwr_d.reg_en   = ~idle_st;
    assign pwr_d.osc_en   = ~idle_st;
    assign pwr_d.xtal_clk = (st_q == RPM_ST_HOLD) | act;
    assign pwr_d.aux_clk  = (st_q == RPM_ST_SLEEP) | (st_q == RPM_ST_START);
    assign pwr_d.vdd_x    = st_q != RPM_ST_OFF;
    assign pwr_d.tx_en    = tx_on;
    assign pwr_d.rx_en    = rx_on;
    assign pwr_d.half_pwr = tx_on & chip_q[RPM_CS_HALF];
    assign pwr_d.sup_5v   = chip_q[RPM_CS_5V];

    // receiver controls; tuning bits 1:0 are stored but drive nothing
    wire [3:0] bsel = rxtune_q[RPM_RT_B7:RPM_RT_B4];
    rpm_rx_t rx_d;
    assign rx_d.main_from_rf_input_two = chip_q[RPM_CS_SWAP];
    assign rx_d.digitizer_en = rx_on;
    assign rx_d.aux_rssi_en  = rx_on;
    assign rx_d.bpf = bsel[3] ? RPM_BPF_110 :
                      bsel[2] ? RPM_BPF_200 :
                      bsel[1] ? RPM_BPF_450 :
                      bsel[0] ? RPM_BPF_100 : RPM_BPF_DEF;
    assign rx_d.gain_cut_7db = ~bsel[3] & ~bsel[2] & ~bsel[1] & bsel[0];
    assign rx_d.win_red = rxtune_q[RPM_RT_WIN+1:RPM_RT_WIN];

    // output flops
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwr   <= '0;
            o_rx    <= '{1'b0, 1'b0, 1'b0, RPM_BPF_DEF, 1'b0, 2'h0};
            o_ready <= 1'b0;
        end else begin
            o_pwr   <= pwr_d;
            o_rx    <= rx_d;
            o_ready <= pwr_d.xtal_clk;
        end
    end

    assign o_prdata  = prdata_q;
    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    en_start_a: assert property ((st_q == RPM_ST_OFF) && en_f |=>
        st_q == RPM_ST_START ##1 (o_pwr.reg_en && o_pwr.osc_en))
        else $error("main enable did not start supplies");
    xtal_switch_a: assert property ((st_q == RPM_ST_START) && up_ok && (en_f || by_wake_q) |=>
        ##1 (o_pwr.xtal_clk && !o_pwr.aux_clk && o_ready))
        else $error("host clock did not switch to crystal");
    wake_start_a: assert property ((st_q == RPM_ST_OFF) && !en_f && wake_rise |=>
        (st_q == RPM_ST_START) && by_wake_q)
        else $error("wake edge did not start supplies");
    hold_time_a: assert property ((st_q == RPM_ST_HOLD) && !en_f && hold_done |=>
        (st_q == RPM_ST_OFF || st_q == RPM_ST_SLEEP))
        else $error("wake hold did not end on time");
    hold_bound_a: assert property ((st_q == RPM_ST_HOLD) |->
        hold_cnt_q < 16'(P_WAKE_HOLD_CYC))
        else $error("wake hold overran");
    sleep_out_a: assert property ((st_q == RPM_ST_SLEEP) |=>
        o_pwr.aux_clk && o_pwr.vdd_x && !o_pwr.xtal_clk && !o_pwr.tx_en && !o_pwr.rx_en)
        else $error("sleep outputs wrong");
    standby_a: assert property (act && stby |=>
        !o_pwr.tx_en && !o_pwr.rx_en && o_pwr.xtal_clk)
        else $error("standby left rf on");
    rx_only_a: assert property (act && !stby && chip_q[1] && !chip_q[5] |=>
        o_pwr.rx_en && !o_pwr.tx_en)
        else $error("receiver-only mode wrong");
    full_rf_a: assert property (act && !stby && chip_q[5] |=>
        o_pwr.rx_en && o_pwr.tx_en && (o_pwr.half_pwr == $past(chip_q[4])))
        else $error("full rf mode wrong");
    swap_a: assert property (1'b1 |=>
        o_rx.main_from_rf_input_two == $past(chip_q[RPM_CS_SWAP]))
        else $error("receiver swap does not follow bit 3");
    preset_a: assert property (wr_commit && hit_proto |=>
        rxtune_q == f_preset($past(i_pwdata[7:0])))
        else $error("protocol write did not reload preset");
    wide_gain_a: assert property ((o_rx.bpf == RPM_BPF_100) |-> o_rx.gain_cut_7db)
        else $error("widest band without gain cut");
    def_bpf_a: assert property ((rxtune_q[7:4] == 4'h0) |=> o_rx.bpf == RPM_BPF_DEF)
        else $error("default band-pass not applied");

    // power sequencer states
    off_state_a: assert property ((st_q == RPM_ST_OFF) |=>
        !o_pwr.reg_en && !o_pwr.osc_en && !o_pwr.vdd_x && !o_pwr.aux_clk && !o_pwr.xtal_clk)
        else $error("power-down left a supply or clock on");
    start_clk_a: assert property ((st_q == RPM_ST_START) |=>
        o_pwr.aux_clk && !o_pwr.xtal_clk && !o_ready)
        else $error("crystal clock shown before start-up ended");
    hold_stay_a: assert property ((st_q == RPM_ST_HOLD) && en_f |=>
        st_q == RPM_ST_ACT)
        else $error("main enable did not keep the wake start");
    sleep_in_a: assert property ((st_q == RPM_ST_HOLD) && !en_f && hold_done && wake_f |=>
        st_q == RPM_ST_SLEEP)
        else $error("wake hold with wake high did not end in sleep");

    // mode decode and supply select
    mode_low_a: assert property (act && !stby && !chip_q[5] && !chip_q[1] |=>
        !o_pwr.tx_en && !o_pwr.rx_en && o_pwr.xtal_clk)
        else $error("low-power active mode left rf on");
    rf_idle_a: assert property (!act |=>
        !o_pwr.tx_en && !o_pwr.rx_en && !o_pwr.half_pwr)
        else $error("rf on outside the active state");
    supply_sel_a: assert property ((st_q != RPM_ST_OFF) |=>
        o_pwr.sup_5v == $past(chip_q[RPM_CS_5V]))
        else $error("supply select does not follow bit 0");
    main_rx_a: assert property (act && !stby && (chip_q[5] || chip_q[1]) |=>
        o_rx.digitizer_en && o_rx.aux_rssi_en)
        else $error("main receiver not feeding the digitizer");

    // receiver tuning
    band_b7_a: assert property (rxtune_q[RPM_RT_B7] |=>
        o_rx.bpf == RPM_BPF_110)
        else $error("bit 7 did not select its band-pass");
    band_b4_a: assert property ((rxtune_q[7:4] == 4'h1) |=>
        (o_rx.bpf == RPM_BPF_100) && o_rx.gain_cut_7db)
        else $error("widest band-pass without its gain cut");
    win_red_a: assert property (1'b1 |=>
        o_rx.win_red == $past(rxtune_q[RPM_RT_WIN+1:RPM_RT_WIN]))
        else $error("gain reduction does not follow bits 3:2");
    tune_write_a: assert property (wr_commit && hit_tune |=>
        rxtune_q == $past(i_pwdata[7:0]))
        else $error("tuning write did not land");

    // main scenarios reached
    sleep_c:      cover property ((st_q == RPM_ST_HOLD) ##1 (st_q == RPM_ST_SLEEP));
    wake_cycle_c: cover property ((st_q == RPM_ST_HOLD) ##1 (st_q == RPM_ST_ACT));
    hold_drop_c:  cover property ((st_q == RPM_ST_HOLD) && hold_done && !en_f);
    full_pwr_c:   cover property (o_pwr.tx_en && !o_pwr.half_pwr);
    bus_err_c:    cover property (o_pready && o_pslverr);
endmodule
`default_nettype wire

// File: hw/rpm_pkg.sv
// constants, states and carrier types of the reader power-mode and receiver-config block
package rpm_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] RPM_IDX_CHIP   = 8'h00;
    localparam logic [7:0] RPM_IDX_PROTO  = 8'h01;
    localparam logic [7:0] RPM_IDX_RXTUNE = 8'h0a;
    localparam logic [7:0] RPM_IDX_STATUS = 8'h10;
    // reset values
    localparam logic [7:0] RPM_CHIP_RST   = 8'h01;
    localparam logic [7:0] RPM_PROTO_RST  = 8'h00;
    localparam logic [7:0] RPM_RXTUNE_RST = 8'h00;
    // chip status control fields
    localparam int RPM_CS_STBY = 7;
    localparam int RPM_CS_TX   = 5;
    localparam int RPM_CS_HALF = 4;
    localparam int RPM_CS_SWAP = 3;
    localparam int RPM_CS_RX   = 1;
    localparam int RPM_CS_5V   = 0;
    // receiver tuning fields
    localparam int RPM_RT_B7   = 7;
    localparam int RPM_RT_B6   = 6;
    localparam int RPM_RT_B5   = 5;
    localparam int RPM_RT_B4   = 4;
    localparam int RPM_RT_WIN  = 2;
    // receiver tuning presets per protocol group (protocol bits 3:2)
    localparam logic [7:0] RPM_PRE_G0 = 8'h40;
    localparam logic [7:0] RPM_PRE_G1 = 8'h20;
    localparam logic [7:0] RPM_PRE_G2 = 8'h80;
    localparam logic [7:0] RPM_PRE_G3 = 8'h00;
    // wake hold window
    localparam int RPM_CLK_MHZ       = 200;
    localparam int RPM_WAKE_HOLD_US  = 100;
    localparam int RPM_WAKE_HOLD_CYC = RPM_WAKE_HOLD_US * RPM_CLK_MHZ;

    typedef enum logic [4:0] {
        RPM_ST_OFF   = 5'b00001,
        RPM_ST_SLEEP = 5'b00010,
        RPM_ST_START = 5'b00100,
        RPM_ST_HOLD  = 5'b01000,
        RPM_ST_ACT   = 5'b10000
    } rpm_state_t;

    typedef enum logic [4:0] {
        RPM_BPF_DEF = 5'b00001,
        RPM_BPF_110 = 5'b00010,
        RPM_BPF_200 = 5'b00100,
        RPM_BPF_450 = 5'b01000,
        RPM_BPF_100 = 5'b10000
    } rpm_bpf_t;

    typedef struct packed {
        logic reg_en;
        logic osc_en;
        logic xtal_clk;
        logic aux_clk;
        logic vdd_x;
        logic tx_en;
        logic rx_en;
        logic half_pwr;
        logic sup_5v;
    } rpm_pwr_t;

    typedef struct packed {
        logic       main_from_rf_input_two;
        logic       digitizer_en;
        logic       aux_rssi_en;
        rpm_bpf_t   bpf;
        logic       gain_cut_7db;
        logic [1:0] win_red;
    } rpm_rx_t;
endpackage

// File: tb/rpm_analog_model.sv
// behavioural regulators and oscillator answering the power controls
`timescale 1ns/100ps
`default_nettype none
module rpm_analog_model
    import rpm_pkg::*;
#(
    parameter int P_SETTLE_CYC = 20,
    parameter int P_OSC_CYC    = 30
) (
    input  wire logic        i_clk,            // 200 mhz clock
    input  wire logic        i_rst_n,          // async reset, low
    input  wire rpm_pwr_t    i_pwr,            // power controls
    output logic             o_supply_settled, // regulators settled
    output logic             o_osc_stable      // oscillator stable
);
    int sup_cnt;
    int osc_cnt;
    // settle and lock counts restart whenever the enables drop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sup_cnt <= 0;
            osc_cnt <= 0;
        end else begin
            sup_cnt <= i_pwr.reg_en ? ((sup_cnt < P_SETTLE_CYC) ? sup_cnt + 1 : sup_cnt) : 0;
            osc_cnt <= i_pwr.osc_en ? ((osc_cnt < P_OSC_CYC) ? osc_cnt + 1 : osc_cnt) : 0;
        end
    end
    assign o_supply_settled = (sup_cnt >= P_SETTLE_CYC);
    assign o_osc_stable     = (osc_cnt >= P_OSC_CYC);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the power-mode and receiver-config block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rpm_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        main_en = 1'b0;
    logic        wake = 1'b0;
    logic        settled;
    logic        osc_ok;
    rpm_pwr_t    pwr;
    rpm_rx_t     rx;
    logic        ready;
    int          bad_count = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  v;
    logic [7:0]  modes [8] = '{8'h21, 8'h31, 8'h03, 8'h01, 8'h81, 8'h20, 8'h00, 8'h02};
    logic [7:0]  tunes [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hf0, 8'h0c, 8'h08, 8'h07, 8'h03};
    logic [7:0]  pres [4];
    rpm_bpf_t    bpf_e;

    always #2.5 i_clk = ~i_clk;

    rpm_core #(.P_WAKE_HOLD_CYC(40)) i_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_main_enable(main_en),
        .i_secondary_wake_input(wake), .i_supply_settled(settled),
        .i_osc_stable(osc_ok), .o_pwr(pwr), .o_rx(rx), .o_ready(ready));

    rpm_analog_model i_analog (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pwr(pwr),
        .o_supply_settled(settled), .o_osc_stable(osc_ok));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) chk("pready", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    // bounded wait on the ready flag
    task automatic wait_rdy(input logic want);
        int n;
        n = 0;
        while (ready !== want && n < 2000) begin
            @(posedge i_clk);
            n++;
        end
        chk("ready", 32'(ready), 32'(want));
    endtask

    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #(60000 * 5);
        bad_count++;
        give_verdict();
    end

    initial begin
        pres = '{RPM_PRE_G0, RPM_PRE_G1, RPM_PRE_G2, RPM_PRE_G3};
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rdc("chip", 12'h000, 32'h01);
        rdc("proto", 12'h004, 32'h00);
        rdc("tune", 12'h028, 32'h00);
        chk("off", 32'({pwr.reg_en, pwr.osc_en, pwr.xtal_clk, pwr.aux_clk, pwr.vdd_x}), 32'h0);
        rdc("unmapped", 12'h100, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        apb(1'b1, 12'h040, 32'hff);
        chk("status wr err", 32'(err), 32'h1);
        // main enable start-up
        main_en <= 1'b1;
        wait_rdy(1'b1);
        chk("clk switch", 32'({pwr.reg_en, pwr.osc_en, pwr.xtal_clk, pwr.aux_clk}), 32'he);
        // power modes from the chip status bits
        foreach (modes[i]) begin
            v = modes[i];
            apb(1'b1, 12'h000, 32'(v));
            repeat (3) @(posedge i_clk);
            chk("mode", 32'({pwr.xtal_clk, pwr.vdd_x, pwr.tx_en, pwr.rx_en, pwr.half_pwr,
                pwr.sup_5v}), 32'({2'b11, !v[7] & v[5], !v[7] & (v[5] | v[1]),
                !v[7] & v[5] & v[4], v[0]}));
            chk("rx path", 32'({rx.digitizer_en, rx.aux_rssi_en}),
                32'({2{!v[7] & (v[5] | v[1])}}));
        end
        apb(1'b1, 12'h000, 32'h09);
        repeat (3) @(posedge i_clk);
        chk("swap", 32'(rx.main_from_rf_input_two), 32'h1);
        apb(1'b1, 12'h000, 32'h01);
        repeat (3) @(posedge i_clk);
        chk("noswap", 32'(rx.main_from_rf_input_two), 32'h0);
        // receiver tuning fields
        foreach (tunes[i]) begin
            v = tunes[i];
            apb(1'b1, 12'h028, 32'(v));
            rdc("tune rb", 12'h028, 32'(v));
            bpf_e = v[7] ? RPM_BPF_110 : v[6] ? RPM_BPF_200 : v[5] ? RPM_BPF_450 :
                    v[4] ? RPM_BPF_100 : RPM_BPF_DEF;
            chk("tune", 32'({rx.bpf, rx.gain_cut_7db, rx.win_red}),
                32'({bpf_e, v[7:4] == 4'b0001, v[3:2]}));
        end
        // protocol write reloads the tuning preset
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, 12'h004, 32'(g << 2));
            rdc("preset", 12'h028, 32'(pres[g]));
        end
        main_en <= 1'b0;
        wait_rdy(1'b0);
        repeat (3) @(posedge i_clk);
        chk("off again", 32'(pwr.reg_en), 32'h0);
        // wake pulse without confirmation; host never raises both pins together
        wake <= 1'b1;
        repeat (10) @(posedge i_clk);
        wake <= 1'b0;
        wait_rdy(1'b1);
        chk("wake up", 32'({pwr.reg_en, pwr.osc_en, pwr.xtal_clk}), 32'h7);
        repeat (20) @(posedge i_clk);
        chk("hold", 32'(ready), 32'h1);
        wait_rdy(1'b0);
        repeat (3) @(posedge i_clk);
        chk("pd", 32'({pwr.reg_en, pwr.vdd_x, pwr.aux_clk}), 32'h0);
        // wake pulse confirmed by main enable, pins changed apart
        wake <= 1'b1;
        repeat (10) @(posedge i_clk);
        wake <= 1'b0;
        wait_rdy(1'b1);
        main_en <= 1'b1;
        repeat (100) @(posedge i_clk);
        chk("confirmed", 32'(ready), 32'h1);
        main_en <= 1'b0;
        wait_rdy(1'b0);
        repeat (20) @(posedge i_clk);
        // wake held high with main low ends in sleep
        wake <= 1'b1;
        wait_rdy(1'b1);
        wait_rdy(1'b0);
        repeat (3) @(posedge i_clk);
        chk("sleep", 32'({pwr.xtal_clk, pwr.aux_clk, pwr.vdd_x, pwr.tx_en, pwr.rx_en}),
            32'h0c);
        give_verdict();
    end
endmodule
`default_nettype wire
